// ### msd_consts.vh
// Contract
// - armed decoder triggers on mode's sync sequence
// - per-mode pattern: none, sync words, 1111/0000/1010
// - sync words programmable, default c4d7 and 3b28
// - message after sync stored slot aligned
// - buffer holds sixteen 128-bit timeslot entries
// - repetitive mode rearms; host reads promptly
// - status bit 12 falls when message arrives
// - buffer reads show slots with message delimiters
// - measure baud rate of each received message
// - slot timing only in control test mode
// - slot timing is the mode after reset
// - slot timing counter clears at slot end
// - slot result: slot end to preamble start
// - response timing only in control and traffic
// - control response counter clears at message end
// - control filler never clears response counter
// - traffic response counter clears at message end
`ifndef MSD_CONSTS_VH
`define MSD_CONSTS_VH

// register byte offsets
`define MSD_A_CTRL      8'h00
`define MSD_A_SYNC_CTL  8'h04
`define MSD_A_SYNC_TRF  8'h08
`define MSD_A_BIT_DIV   8'h0c
`define MSD_A_STATUS    8'h10
`define MSD_A_INT_STAT  8'h14
`define MSD_A_INT_MASK  8'h18
`define MSD_A_BUF_SEL   8'h1c
`define MSD_A_BUF_D0    8'h20
`define MSD_A_BUF_D1    8'h24
`define MSD_A_BUF_D2    8'h28
`define MSD_A_BUF_D3    8'h2c
`define MSD_A_UNREAD    8'h30
`define MSD_A_BAUD      8'h34
`define MSD_A_TIMING    8'h38
`define MSD_A_START     8'h3c

// control and status fields
`define MSD_C_ARM       0
`define MSD_C_REP       1
`define MSD_C_MODE_LO   2
`define MSD_C_MODE_HI   4
`define MSD_C_TRESP     5
`define MSD_C_INV       6
`define MSD_S_RESULT    12
`define MSD_S_TMR_EN    13

// test modes
`define MSD_M_OFF       3'h0
`define MSD_M_CTL       3'h1
`define MSD_M_TRF       3'h2
`define MSD_M_1200      3'h3
`define MSD_M_1800      3'h4
`define MSD_M_DOT       3'h5

// tone patterns, reset values, sizes
`define MSD_P_1200      4'hf
`define MSD_P_1800      4'h0
`define MSD_P_DOT       4'ha
`define MSD_SYNC_CTL_RST 16'hc4d7
`define MSD_SYNC_TRF_RST 16'h3b28
`define MSD_BIT_DIV_RST 20'h14585
`define MSD_SYNC_BITS   12'h010
`define MSD_SLOT_LAST   7'h7f

`endif

// ### msd_decoder.v
// The register offsets and the APB slave port were left to the implementer.
`include "msd_consts.vh"
`default_nettype none

module msd_decoder #(
  parameter [19:0] BIT_DIV_RST = `MSD_BIT_DIV_RST, // cycles per bit
  parameter [11:0] PRE_BITS    = 12'h010,          // preamble length
  parameter [7:0]  GAP_BITS    = 8'h10             // continuation gap
) (
  input  wire        ref_clk,      // 100 mhz clock
  input  wire        rstn,         // async reset, low
  input  wire        rx_data,      // demodulated data pin
  input  wire        ctl_slot_end, // encoder: control slot ended
  input  wire        ctl_msg_end,  // encoder: control buffer msg ended
  input  wire        ctl_filler,   // encoder: filler being sent
  input  wire        trf_msg_end,  // encoder: traffic msg ended
  input  wire [7:0]  paddr,        // apb address
  input  wire        psel,         // apb select
  input  wire        penable,      // apb enable
  input  wire        pwrite,       // apb direction
  input  wire [31:0] pwdata,       // apb write data
  output reg  [31:0] prdata,       // apb read data
  output reg         pready,       // apb ready
  output reg         pslverr,      // apb error, unmapped address
  output reg         irq           // level interrupt
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_HUNT = 2'h1;
  localparam [1:0] ST_CAPT = 2'h2;
  localparam [11:0] LEAD_BITS = PRE_BITS + `MSD_SYNC_BITS;

  // sync word compare; tones must repeat four times
  function pat_hit;
    input [2:0]  mode;
    input [15:0] sh;
    input [15:0] s_ctl;
    input [15:0] s_trf;
    begin
      case (mode)
        `MSD_M_CTL:  pat_hit = (sh == s_ctl);
        `MSD_M_TRF:  pat_hit = (sh == s_trf);
        `MSD_M_1200: pat_hit = (sh == {4{`MSD_P_1200}});
        `MSD_M_1800: pat_hit = (sh == {4{`MSD_P_1800}});
        `MSD_M_DOT:  pat_hit = (sh == {4{`MSD_P_DOT}});
        default:     pat_hit = 1'b0;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // state

  reg  [2:0]   rx_sync_r;
  reg          rx_lvl_r;
  reg          rx_prev_r;
  reg  [19:0]  ph_r;
  reg          bit_stb_r;
  reg          bit_val_r;
  reg  [15:0]  sh_r;
  reg  [1:0]   state_r;
  reg  [127:0] cap_r;
  reg  [6:0]   bcnt_r;
  reg  [31:0]  bcyc_r;
  reg  [7:0]   gap_r;
  reg  [127:0] mem [0:15];
  reg  [3:0]   wr_ptr_r;
  reg  [15:0]  unread_r;
  reg  [15:0]  start_r;
  reg          rep_r;
  reg  [2:0]   mode_r;
  reg          tresp_r;
  reg          inv_r;
  reg  [15:0]  sync_ctl_r;
  reg  [15:0]  sync_trf_r;
  reg  [19:0]  bit_div_r;
  reg  [3:0]   buf_sel_r;
  reg  [31:0]  baud_r;
  reg  [31:0]  tmr_r;
  reg  [31:0]  timing_r;
  reg          stat12_r;
  reg  [1:0]   int_stat_r;
  reg  [1:0]   int_mask_r;
  reg  [31:0]  rd_mux;
  reg          rd_err;

  wire         wr_acc = psel & penable & pwrite & pready;
  wire         rd_acc = psel & penable & ~pwrite & pready;
  wire         rx_edge = rx_lvl_r ^ rx_prev_r;
  wire [15:0]  nsh = {sh_r[14:0], bit_val_r};
  wire         hit = bit_stb_r & (state_r == ST_HUNT) &
                     pat_hit(mode_r, nsh, sync_ctl_r, sync_trf_r);
  wire         store = bit_stb_r & (state_r == ST_CAPT) &
                       (bcnt_r == `MSD_SLOT_LAST);
  wire         arm_wr = wr_acc & (paddr == `MSD_A_CTRL);
  wire [127:0] sel_word = mem[buf_sel_r];
  wire [31:0]  lead_w = {12'h000, bit_div_r} * {20'h00000, LEAD_BITS};
  wire         tmr_en = tresp_r ?
                 (mode_r == `MSD_M_CTL) | (mode_r == `MSD_M_TRF) :
                 (mode_r == `MSD_M_CTL);
  wire         tmr_clr = tresp_r ?
                 ((mode_r == `MSD_M_CTL) & ctl_msg_end &
                  ~ctl_filler) |
                 ((mode_r == `MSD_M_TRF) & trf_msg_end) :
                 ((mode_r == `MSD_M_CTL) & ctl_slot_end);
  reg  [1:0]   state_nxt;
  // result event is the store itself, the cycle bit 12 dips
  wire [1:0]   int_ev = {store & unread_r[wr_ptr_r],
                         store};
  wire [1:0]   int_nxt = (int_stat_r & ~((wr_acc &
                 (paddr == `MSD_A_INT_STAT)) ? pwdata[1:0] : 2'h0))
                 | int_ev;

  //////////////////////////////////////////////////////////////////////
  // pin synchroniser; a change counts once stages two and three agree

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_sync_r <= 3'h0;
      rx_lvl_r  <= 1'b0;
      rx_prev_r <= 1'b0;
    end else begin
      rx_sync_r <= {rx_sync_r[1:0], rx_data};
      rx_prev_r <= rx_lvl_r;
      if (rx_sync_r[1] == rx_sync_r[2]) begin
        rx_lvl_r <= rx_sync_r[2];
      end
    end
  end

  // bit clock recovery: each edge re-centres the sample point
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ph_r      <= 20'h00000;
      bit_stb_r <= 1'b0;
      bit_val_r <= 1'b0;
      sh_r      <= 16'h0000;
    end else begin
      bit_stb_r <= 1'b0;
      if (rx_edge) begin
        ph_r <= {1'b0, bit_div_r[19:1]};
      end else if (ph_r == 20'h00000) begin
        ph_r      <= bit_div_r - 20'h00001;
        bit_stb_r <= 1'b1;
        bit_val_r <= rx_lvl_r ^ inv_r;
      end else begin
        ph_r <= ph_r - 20'h00001;
      end
      if (bit_stb_r) begin
        sh_r <= nsh;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // trigger sequencer

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_HUNT: begin
        if (hit) begin
          state_nxt = ST_CAPT;
        end
      end
      ST_CAPT: begin
        if (store) begin
          state_nxt = rep_r ? ST_HUNT : ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // software arming overrides the sequencer
    if (arm_wr) begin
      state_nxt = pwdata[`MSD_C_ARM] ? ST_HUNT : ST_IDLE;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r  <= ST_IDLE;
      cap_r    <= 128'h0;
      bcnt_r   <= 7'h00;
      bcyc_r   <= 32'h00000000;
      baud_r   <= 32'h00000000;
      gap_r    <= 8'hff;
      stat12_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      // bit 12 dips only on a store; a disarm must not fake a result
      stat12_r <= ~store;
      if (hit) begin
        bcnt_r <= 7'h00;
        // the hit cycle counts, so 128 bits give 128 bit periods
        bcyc_r <= 32'h00000001;
      end else if (state_r == ST_CAPT) begin
        bcyc_r <= bcyc_r + 32'h00000001;
        if (bit_stb_r) begin
          cap_r  <= {cap_r[126:0], bit_val_r};
          bcnt_r <= bcnt_r + 7'h01;
        end
      end
      // cycles per bit over the slot; 128 bits, so shift by 7
      if (store) begin
        baud_r <= {7'h00, bcyc_r[31:7]};
      end
      if (store) begin
        gap_r <= 8'h00;
      end else if (bit_stb_r & (state_r != ST_CAPT) &
                   (gap_r != 8'hff)) begin
        // only bits outside a slot count as gap
        gap_r <= gap_r + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // receive buffer; unread slots may be overwritten, flagged as irq

  always @(posedge ref_clk) begin
    if (store) begin
      mem[wr_ptr_r] <= {cap_r[126:0], bit_val_r};
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= 4'h0;
      unread_r <= 16'h0000;
      start_r  <= 16'h0000;
    end else begin
      // reading word 3 frees the slot; a new store wins
      if (rd_acc & (paddr == `MSD_A_BUF_D3)) begin
        unread_r[buf_sel_r] <= 1'b0;
      end
      if (store) begin
        wr_ptr_r           <= wr_ptr_r + 4'h1;
        unread_r[wr_ptr_r] <= 1'b1;
        // a slot not following closely opens a new message
        start_r[wr_ptr_r]  <= (gap_r > GAP_BITS);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // message timing; result is referred back to preamble start

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tmr_r    <= 32'h00000000;
      timing_r <= 32'h00000000;
    end else begin
      if (tmr_clr) begin
        tmr_r <= 32'h00000000;
      end else if (tmr_r != 32'hffffffff) begin
        tmr_r <= tmr_r + 32'h00000001;
      end
      // no clamp: a sync before a full lead wraps the value
      if (hit & tmr_en) begin
        timing_r <= {1'b1, tmr_r[30:0] - lead_w[30:0]};
      end else if (hit) begin
        timing_r <= 32'h00000000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, ready high in the access cycle after setup

  always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    if (paddr == `MSD_A_CTRL) begin
      rd_mux = {25'h0, inv_r, tresp_r, mode_r, rep_r,
                state_r != ST_IDLE};
    end else if (paddr == `MSD_A_SYNC_CTL) begin
      rd_mux = {16'h0000, sync_ctl_r};
    end else if (paddr == `MSD_A_SYNC_TRF) begin
      rd_mux = {16'h0000, sync_trf_r};
    end else if (paddr == `MSD_A_BIT_DIV) begin
      rd_mux = {12'h000, bit_div_r};
    end else if (paddr == `MSD_A_STATUS) begin
      rd_mux[1:0]            = state_r;
      rd_mux[`MSD_S_RESULT]  = stat12_r;
      rd_mux[`MSD_S_TMR_EN]  = tmr_en;
    end else if (paddr == `MSD_A_INT_STAT) begin
      rd_mux = {30'h0, int_stat_r};
    end else if (paddr == `MSD_A_INT_MASK) begin
      rd_mux = {30'h0, int_mask_r};
    end else if (paddr == `MSD_A_BUF_SEL) begin
      rd_mux = {24'h0, wr_ptr_r, buf_sel_r};
    end else if (paddr == `MSD_A_BUF_D0) begin
      rd_mux = sel_word[127:96];
    end else if (paddr == `MSD_A_BUF_D1) begin
      rd_mux = sel_word[95:64];
    end else if (paddr == `MSD_A_BUF_D2) begin
      rd_mux = sel_word[63:32];
    end else if (paddr == `MSD_A_BUF_D3) begin
      rd_mux = sel_word[31:0];
    end else if (paddr == `MSD_A_UNREAD) begin
      rd_mux = {16'h0000, unread_r};
    end else if (paddr == `MSD_A_BAUD) begin
      rd_mux = baud_r;
    end else if (paddr == `MSD_A_TIMING) begin
      rd_mux = timing_r;
    end else if (paddr == `MSD_A_START) begin
      rd_mux = {16'h0000, start_r};
    end else begin
      rd_err = 1'b1;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & rd_err;
      if (psel & ~penable & ~pready) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  // writable registers
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rep_r      <= 1'b0;
      mode_r     <= `MSD_M_OFF;
      tresp_r    <= 1'b0;
      inv_r      <= 1'b0;
      sync_ctl_r <= `MSD_SYNC_CTL_RST;
      sync_trf_r <= `MSD_SYNC_TRF_RST;
      bit_div_r  <= BIT_DIV_RST;
      buf_sel_r  <= 4'h0;
      int_mask_r <= 2'h0;
    end else if (wr_acc) begin
      if (paddr == `MSD_A_CTRL) begin
        rep_r   <= pwdata[`MSD_C_REP];
        mode_r  <= pwdata[`MSD_C_MODE_HI:`MSD_C_MODE_LO];
        tresp_r <= pwdata[`MSD_C_TRESP];
        inv_r   <= pwdata[`MSD_C_INV];
      end else if (paddr == `MSD_A_SYNC_CTL) begin
        sync_ctl_r <= pwdata[15:0];
      end else if (paddr == `MSD_A_SYNC_TRF) begin
        sync_trf_r <= pwdata[15:0];
      end else if (paddr == `MSD_A_BIT_DIV) begin
        bit_div_r <= pwdata[19:0];
      end else if (paddr == `MSD_A_BUF_SEL) begin
        buf_sel_r <= pwdata[3:0];
      end else if (paddr == `MSD_A_INT_MASK) begin
        int_mask_r <= pwdata[1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // interrupt: sticky events, write one to clear, set wins

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      int_stat_r <= 2'h0;
      irq        <= 1'b0;
    end else begin
      int_stat_r <= int_nxt;
      irq        <= |(int_nxt & int_mask_r);
    end
  end

endmodule

`default_nettype wire

// ### msd_decoder_monitor.sv
`include "msd_consts.vh"
`default_nettype none
module msd_decoder_monitor (
  input wire logic        ref_clk, // clock
  input wire logic        rstn,    // reset, low
  input wire logic [7:0]  paddr,   // apb address
  input wire logic        psel,    // apb select
  input wire logic        penable, // apb enable
  input wire logic        pwrite,  // apb direction
  input wire logic [31:0] pwdata,  // apb write data
  input wire logic [31:0] prdata,  // apb read data
  input wire logic        pready,  // apb ready
  input wire logic        pslverr, // apb error
  input wire logic        irq      // interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////
  // setup phase, and aligned words inside the register map
  wire setup = psel && !penable;
  wire mapped = paddr <= `MSD_A_START && paddr[1:0] == 2'h0;
  //////////////////////////////////////////////////////////////////////
  setup_ready_a: assert property (setup |=> pready)
    else $error("no ready after setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  unmapped_err_a: assert property (setup && !mapped |=> pready && pslverr)
    else $error("no error on unmapped address");
  mapped_ok_a: assert property (setup && mapped |=> !pslverr)
    else $error("error on mapped address");
  err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  mask_off_a: assert property (pready && pwrite
      && paddr == `MSD_A_INT_MASK && pwdata == 32'h0 |=> ##1 !irq[*2])
    else $error("irq with mask cleared");
  reset_quiet_a: assert property ($rose(rstn) |-> !pready && !irq)
    else $error("outputs busy after reset");
  // main scenarios seen
  cover property (pready && pslverr);
  cover property (pready && pwrite);
  cover property ($fell(irq));
endmodule
bind msd_decoder msd_decoder_monitor i_mon (.ref_clk(ref_clk), .rstn(rstn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq));
`default_nettype wire

// ### msd_radio_model.sv
`default_nettype none
module msd_radio_model (
  input wire logic       ref_clk, // bench clock
  input wire logic [7:0] div,     // cycles per bit
  output var logic       rx_data  // serial line to decoder
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       q[$];
  logic [1:0] idle_ph = 2'h0;
  int         cnt = 0;
  initial rx_data = 1'b0;
  // guard bit breaks the pattern so sync cannot match a bit early
  task automatic push(input logic [15:0] sync, input logic [127:0] pay);
    q.push_back(sync == 16'haaaa ? 1'b1 : ~sync[15]);
    for (int i = 15; i >= 0; i--) q.push_back(sync[i]);
    for (int i = 127; i >= 0; i--) q.push_back(pay[i]);
  endtask
  // one bit per div cycles; idle runs 0011, which forms no sync word
  always @(posedge ref_clk) begin
    if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      cnt <= div;
      if (q.size() > 0) begin
        rx_data <= q.pop_front();
      end else begin
        rx_data <= idle_ph[1];
        idle_ph <= idle_ph + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### msd_decoder_tb.sv
`include "msd_consts.vh"
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  err_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
  end end
module msd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic         ref_clk = 1'b0;
  logic         rstn = 1'b0;
  logic         rx_data;
  logic         slot_end = 1'b0;
  logic         msg_end = 1'b0;
  logic         filler = 1'b0;
  logic [7:0]   paddr = 8'h0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         irq;
  logic         last_err;
  int           err_count = 0;
  int           comparisons = 0;
  logic [127:0] exp_q[$];
  always #5 ref_clk = ~ref_clk;
  msd_decoder i_msd_decoder (.ref_clk(ref_clk), .rstn(rstn),
    .rx_data(rx_data), .ctl_slot_end(slot_end), .ctl_msg_end(msg_end),
    .ctl_filler(filler), .trf_msg_end(msg_end), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  msd_radio_model i_radio (.ref_clk(ref_clk), .div(8'h8),
    .rx_data(rx_data));
  //////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one transfer; an idle cycle after it keeps strobes to one change
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      summarize();
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r);
  endtask
  // sync sequence expected for each test mode
  function automatic logic [15:0] pat(input int m);
    case (m)
      1: return 16'h2e71;
      2: return `MSD_SYNC_TRF_RST;
      3: return {4{`MSD_P_1200}};
      4: return {4{`MSD_P_1800}};
      default: return {4{`MSD_P_DOT}};
    endcase
  endfunction
  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0]  r;
    logic [127:0] pay;
    logic         en;
    logic         inv;
    int           n;
    int           slot;
    void'($urandom(92425));
    slot = 0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(`MSD_A_CTRL, r);
    `CHK(r[5], 1'b0)
    rd(`MSD_A_SYNC_CTL, r);
    `CHK(r[15:0], `MSD_SYNC_CTL_RST)
    rd(`MSD_A_SYNC_TRF, r);
    `CHK(r[15:0], `MSD_SYNC_TRF_RST)
    rd(8'h40, r);
    `CHK({last_err, r}, {1'b1, 32'h0})
    wr(`MSD_A_BIT_DIV, 32'h8);
    wr(`MSD_A_INT_MASK, 32'h1);
    wr(`MSD_A_SYNC_CTL, 32'h2e71);
    rd(`MSD_A_SYNC_CTL, r);
    `CHK(r[15:0], 16'h2e71)
    // armed but mode off: a sync word must not trigger
    wr(`MSD_A_CTRL, 32'h1);
    i_radio.push(16'h3b28, 128'h0);
    repeat (1400) @(posedge ref_clk);
    rd(`MSD_A_INT_STAT, r);
    `CHK(r, 32'h0)
    for (int t = 0; t < 2; t++) begin
      for (int m = 1; m < 6; m++) begin
        en = t ? (m < 3) : (m == 1);
        // inverted line polarity exercised once, on the control word
        inv = t[0] & (m == 1);
        wr(`MSD_A_CTRL, {25'h0, inv, t[0], m[2:0], t[0], 1'b1});
        rd(`MSD_A_STATUS, r);
        `CHK({r[13:12], r[1:0]}, {en, 1'b1, 2'h1})
        // forward slot and message end before the radio answers
        slot_end <= 1'b1;
        msg_end <= 1'b1;
        @(posedge ref_clk);
        slot_end <= 1'b0;
        msg_end <= 1'b0;
        pay = {$urandom(), $urandom(), $urandom(), $urandom()};
        i_radio.push(inv ? ~pat(m) : pat(m), inv ? ~pay : pay);
        exp_q.push_back(pay);
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
          @(posedge ref_clk);
          n++;
        end
        `CHK(n < 3000, 1'b1)
        if (n >= 3000) summarize();
        wr(`MSD_A_INT_MASK, 32'h0);
        @(posedge ref_clk);
        `CHK(irq, 1'b0)
        wr(`MSD_A_INT_MASK, 32'h1);
        rd(`MSD_A_INT_STAT, r);
        `CHK(r[1:0], 2'h1)
        wr(`MSD_A_INT_STAT, 32'h3);
        rd(`MSD_A_UNREAD, r);
        `CHK(r, 32'h1 << slot)
        wr(`MSD_A_BUF_SEL, 32'(slot));
        rd(`MSD_A_BUF_SEL, r);
        `CHK(r[7:0], {4'(slot + 1), 4'(slot)})
        pay = exp_q.pop_front();
        for (int k = 0; k < 4; k++) begin
          rd(`MSD_A_BUF_D0 + 8'(4 * k), r);
          `CHK(r, pay[127 - 32 * k -: 32])
        end
        rd(`MSD_A_START, r);
        `CHK(r[slot], 1'b1)
        rd(`MSD_A_BAUD, r);
        `CHK(r, 32'h8)
        rd(`MSD_A_TIMING, r);
        `CHK(en ? {31'h0, r[31]} : r, {31'h0, en})
        rd(`MSD_A_CTRL, r);
        `CHK(r[0], t[0])
        `CHK(r[6], inv)
        wr(`MSD_A_CTRL, 32'h0);
        slot++;
      end
    end
    summarize();
  end
endmodule
`default_nettype wire
